// ==== rtl/acr_top.sv ====
// Sequencer and serial read-out of a delta-sigma converter.
// Assumes filtered code and offset arrive on CLK; SCK and CS_N are host pins.
//
// How it works
// [R1] States run converting, sleeping, data output, then converting again.
// [R2] Conversion lasts a fixed timed count of CLK cycles, ignoring the pins.
// [R3] Pin activity never aborts a conversion; only the power-on reset does.
// [R4] Sleep is left for output once chip select and serial clock are low.
// [R5] Sleeping with chip select high asserts the low-power indication.
// [R6] The result register is untouched during sleep.
// [R7] Entering output puts the result sign bit on the data pin at once.
// [R8] Each serial clock fall after a rise moves to the next bit, MSB first.
// [R9] The host samples data on serial clock rising edges.
// [R10] The sixteenth shifting fall ends output and starts a conversion.
// [R11] Chip select rising during output aborts it and starts converting.
// [R12] After supply reset an internal 0.5 ms reset clears everything.
// [R13] When that internal reset ends, a conversion begins.
// [R14] Each read-out carries the latest conversion, one word per conversion.
// [R15] Result is offset binary around 32768, clamped to 0 and 65535.
// [R16] The first bit is one when the difference is not negative.
// [R17] Host keeps chip select low through a read-out; raising it aborts.
// [R18] Offset is captured and removed within every conversion.
// [R19] The data pin is driven while chip select, delayed three CLK edges by synchroniser and register, is low.
// [R20] With clock high and select low, data reads busy high, done low.
// [R21] Chip select, serial clock and link flags pass two-flop synchronisers.
`include "acr_map.svh"
module acr_top #(
    parameter int RAW_W      = 20,
    parameter int CONV_CYCLES = int'(`ACR_CONV_TIME_MS * 1000.0 * `ACR_CLK_MHZ),
    parameter int POR_CYCLES  = int'(`ACR_POR_TIME_MS * 1000.0 * `ACR_CLK_MHZ)
) (
    // Clock and supply-monitor reset
    input  wire logic                    CLK,
    input  wire logic                    RESET,
    // Serial link
    input  wire logic                    SCK,
    input  wire logic                    CS_N,
    output logic                         SDO_O,
    output logic                         SDO_OE,
    // Modulator and filter
    input  wire logic signed [RAW_W-1:0] MOD_CODE,
    input  wire logic signed [RAW_W-1:0] OFFSET_CODE,
    output logic                         CAL_STROBE,
    // Status
    output logic                         CONV_ACTIVE,
    output logic                         LOW_POWER
);
    localparam int TW = $clog2(CONV_CYCLES + POR_CYCLES + 1);
    localparam logic [TW-1:0] CONV_LAST = TW'(CONV_CYCLES - 1);
    localparam logic [TW-1:0] POR_LAST  = TW'(POR_CYCLES - 1);
    localparam logic [TW-1:0] CAL_POINT = TW'(CONV_CYCLES / 2);

    acr_link_if lk ();

    acr_pkg::acr_state_type state_r;
    acr_pkg::acr_state_type state_nxt;
    logic [TW-1:0]          timer_r;
    logic [3:0]             sync1_r;
    logic [3:0]             sync2_r;
    logic                   cs_s;
    logic                   sck_s;
    logic                   done_s;
    logic                   entered_s;
    logic [15:0]            result_r;
    logic signed [RAW_W-1:0] offset_r;
    logic                   busy_r;
    logic                   show_r;

    // ==========================================================
    // Offset removal and clamp to offset binary
    function automatic logic [15:0] to_code(input logic signed [RAW_W-1:0] raw,
                                            input logic signed [RAW_W-1:0] off);
        logic signed [RAW_W:0] diff;
        diff = (RAW_W+1)'(raw) - (RAW_W+1)'(off);
        if (diff > (RAW_W+1)'(32767))
            to_code = `ACR_MAX_CODE; // [R15]
        else if (diff < -(RAW_W+1)'(32768))
            to_code = `ACR_MIN_CODE; // [R15]
        else
            to_code = diff[15:0] ^ `ACR_MID_CODE; // [R15] [R16]
    endfunction

    // ==========================================================
    // Synchronisers: pins and link flags
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
        end
        else
        begin
            sync1_r <= {CS_N, SCK, lk.done, lk.entered}; // [R21]
            sync2_r <= sync1_r; // [R21]
        end
    end

    assign cs_s      = sync2_r[3];
    assign sck_s     = sync2_r[2];
    assign done_s    = sync2_r[1] & ~RESET;
    assign entered_s = sync2_r[0] & ~RESET;

    // ==========================================================
    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            acr_pkg::ST_POR:
            begin
                if (timer_r == POR_LAST)
                    state_nxt = acr_pkg::ST_CONV; // [R13]
            end
            acr_pkg::ST_CONV:
            begin
                // Pins are not looked at here
                if (timer_r == CONV_LAST)
                    state_nxt = acr_pkg::ST_SLEEP; // [R2] [R3]
            end
            acr_pkg::ST_SLEEP:
            begin
                if ((!cs_s && !sck_s) || entered_s || done_s)
                    state_nxt = acr_pkg::ST_OUT; // [R4]
            end
            acr_pkg::ST_OUT:
            begin
                // Select already high here means it rose during output
                if (done_s || cs_s)
                    state_nxt = acr_pkg::ST_CONV; // [R10] [R11] [R17]
            end
            default:
                state_nxt = acr_pkg::ST_POR;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            state_r <= acr_pkg::ST_POR; // [R12]
        else
            state_r <= state_nxt; // [R1]
    end

    // Shared timer: power-on reset interval, then conversion period
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            timer_r <= '0;
        else if (state_nxt != state_r)
            timer_r <= '0;
        else if (state_r == acr_pkg::ST_POR || state_r == acr_pkg::ST_CONV)
            timer_r <= timer_r + TW'(1); // [R2] [R12]
        else
            timer_r <= '0;
    end

    // ==========================================================
    // Calibration and result
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            offset_r   <= '0;
            CAL_STROBE <= 1'b0;
        end
        else
        begin
            CAL_STROBE <= (state_r == acr_pkg::ST_CONV) && (timer_r == CAL_POINT); // [R18]
            if (CAL_STROBE)
                offset_r <= OFFSET_CODE; // [R18]
        end
    end

    // Only the conversion end and the supply and internal resets write; sleep and output leave it alone
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            result_r <= `ACR_RES_RESET; // [R12]
        else if (state_r == acr_pkg::ST_POR)
            result_r <= `ACR_RES_RESET; // [R12]
        else if (state_r == acr_pkg::ST_CONV && timer_r == CONV_LAST)
            result_r <= to_code(MOD_CODE, offset_r); // [R6] [R14]
    end

    // ==========================================================
    // Link flags and pins
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            busy_r      <= 1'b1;
            show_r      <= 1'b0;
            CONV_ACTIVE <= 1'b0;
            LOW_POWER   <= 1'b0;
            SDO_OE      <= 1'b0;
        end
        else
        begin
            busy_r      <= (state_nxt == acr_pkg::ST_POR) || (state_nxt == acr_pkg::ST_CONV);
            show_r      <= (state_nxt == acr_pkg::ST_OUT); // [R7]
            CONV_ACTIVE <= (state_nxt == acr_pkg::ST_CONV);
            LOW_POWER   <= (state_r == acr_pkg::ST_SLEEP) && cs_s; // [R5]
            SDO_OE      <= ~cs_s; // [R19]
        end
    end

    assign lk.result = result_r;
    assign lk.busy   = busy_r;
    assign lk.show   = show_r;
    // Bit changes on SCK faster than CLK, so the pin follows the link side
    assign SDO_O     = lk.sdo;

    acr_link u_link (
        .sck  (SCK),
        .cs_n (CS_N),
        .lk   (lk)
    );
endmodule

// ==== rtl/acr_map.svh ====
// Offsets, reset values and timing figures for the converter sequencer.
// Assumes it is included by bare name wherever these figures are needed.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ==========================================================
// Result format
`define ACR_RES_W        16
`define ACR_RES_MSB      15
`define ACR_MID_CODE     16'h8000
`define ACR_MAX_CODE     16'hffff
`define ACR_MIN_CODE     16'h0000
`define ACR_RES_RESET    16'h0000
`define ACR_SHIFT_COUNT  5'h10

// ==========================================================
// Timing
`define ACR_CLK_MHZ      10.0
`define ACR_CONV_TIME_MS 16.6
`define ACR_POR_TIME_MS  0.5

`endif

// ==== rtl/acr_pkg.sv ====
// Types shared by the converter sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package acr_pkg;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_POR   = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_OUT   = 4'b1000
    } acr_state_type;

endpackage

// ==== rtl/acr_link_if.sv ====
// Signals between the sequencer core and its serial-clock side.
// Assumes the core drives result, busy and show; the link side drives the rest.
interface acr_link_if;
    logic [15:0] result;
    logic        busy;
    logic        show;
    logic        done;
    logic        entered;
    logic        sdo;

    modport core (output result, output busy, output show,
                  input done, input entered, input sdo);
    modport link (input result, input busy, input show,
                  output done, output entered, output sdo);
endinterface

// ==== rtl/acr_link.sv ====
// Serial-clock side of the read-out: counts shifts and picks the output bit.
// Assumes result is held static by the core while busy is low.
`include "acr_map.svh"
module acr_link (
    // Link pins
    input  wire logic sck,
    input  wire logic cs_n,
    // Core side
    acr_link_if.link  lk
);
    logic       clr;
    logic       rise_seen_r;
    logic       entered_r;
    logic [4:0] count_r;

    // ==========================================================
    // Clear while deselected or converting; SCK may be stopped then
    assign clr = cs_n | lk.busy; // [R11]

    always_ff @(posedge sck or posedge clr)
    begin
        if (clr)
            rise_seen_r <= 1'b0;
        else
            rise_seen_r <= 1'b1;
    end

    // First fall with SCK idling high only enters output, it does not shift
    always_ff @(negedge sck or posedge clr)
    begin
        if (clr)
        begin
            entered_r <= 1'b0;
            count_r   <= 5'h00;
        end
        else
        begin
            entered_r <= 1'b1; // [R4]
            if (rise_seen_r && count_r != `ACR_SHIFT_COUNT)
                count_r <= count_r + 5'h01; // [R8]
        end
    end

    // ==========================================================
    // Output bit
    always_comb
    begin
        if (lk.busy)
            lk.sdo = 1'b1; // [R20]
        else if (!(lk.show || entered_r))
            lk.sdo = 1'b0; // [R20]
        else if (count_r < `ACR_SHIFT_COUNT)
            lk.sdo = lk.result[4'(`ACR_RES_MSB - count_r)]; // [R7] [R8]
        else
            lk.sdo = 1'b0;
    end

    assign lk.done    = (count_r == `ACR_SHIFT_COUNT); // [R10]
    assign lk.entered = entered_r;
endmodule

// ==== dv/acr_top_asserts.sv ====
// Checker on the sequencer top ports.
// Assumes CLK is the core clock and RESET its async reset.
module acr_top_asserts #(
    parameter int CONV_CYCLES = 166000,
    parameter int POR_CYCLES  = 5000
) (
    // Core
    input wire logic CLK,
    input wire logic RESET,
    // Link
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SDO_O,
    input wire logic SDO_OE,
    // Status
    input wire logic CAL_STROBE,
    input wire logic CONV_ACTIVE,
    input wire logic LOW_POWER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // ====================
    // Helpers
    int   conv_cnt_r;
    int   since_r;
    logic seen_r;
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            conv_cnt_r <= 0;
            since_r    <= 0;
            seen_r     <= 1'b0;
        end
        else
        begin
            conv_cnt_r <= CONV_ACTIVE ? conv_cnt_r + 1 : 0;
            since_r    <= seen_r ? since_r : since_r + 1;
            seen_r     <= seen_r | CONV_ACTIVE;
        end
    end
    // ====================
    // Properties
    property p_oe_off; CS_N [*4] |=> !SDO_OE; endproperty
    a_oe_off: assert property (p_oe_off) else $error("driven while deselected");
    property p_conv_len; $fell(CONV_ACTIVE) |-> conv_cnt_r == CONV_CYCLES; endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length");
    property p_conv_max; conv_cnt_r <= CONV_CYCLES; endproperty
    a_conv_max: assert property (p_conv_max) else $error("conversion overran");
    property p_lp; LOW_POWER |-> !CONV_ACTIVE && seen_r; endproperty
    a_lp: assert property (p_lp) else $error("low power outside sleep");
    property p_stay; LOW_POWER && CS_N |=> !CONV_ACTIVE; endproperty
    a_stay: assert property (p_stay) else $error("left sleep while deselected");
    property p_busy; CONV_ACTIVE [*3] ##0 SDO_OE |-> SDO_O; endproperty
    a_busy: assert property (p_busy) else $error("status low while converting");
    // Allows the flop and synchroniser lag after the internal reset
    property p_por; $rose(CONV_ACTIVE) && !seen_r |-> since_r inside {[POR_CYCLES-1:POR_CYCLES+2]};
    endproperty
    a_por: assert property (p_por) else $error("first conversion start");
    property p_abort;
        (!CS_N && !SCK && seen_r && !CONV_ACTIVE) [*4] ##1 CS_N [*4] |-> ##[0:4] CONV_ACTIVE;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not convert");
    property p_cal; CAL_STROBE |-> CONV_ACTIVE ##1 (CONV_ACTIVE && !CAL_STROBE); endproperty
    a_cal: assert property (p_cal) else $error("calibration outside conversion");
    c_cal: cover property (CAL_STROBE);
    c_sleep: cover property (LOW_POWER);
    c_restart: cover property ($rose(CONV_ACTIVE) && seen_r);
endmodule

bind acr_top acr_top_asserts #(.CONV_CYCLES(CONV_CYCLES), .POR_CYCLES(POR_CYCLES)) u_asserts (
    .CLK(CLK), .RESET(RESET), .SCK(SCK), .CS_N(CS_N), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
    .CAL_STROBE(CAL_STROBE), .CONV_ACTIVE(CONV_ACTIVE), .LOW_POWER(LOW_POWER));

// ==== dv/acr_host_model.sv ====
// Host serial master model for the converter read-out.
// Assumes sdo is the resolved data wire as the host sees it.
module acr_host_model (
    // Link pins
    output logic      sck,
    output logic      cs_n,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 40;
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
    end
    // ====================
    // Long select setup: the core sees select only through a synchroniser
    task automatic frame(input logic cpol, input int nbits, output logic [15:0] w,
                         output logic tail);
        sck = cpol;
        #17 cs_n = 1'b0;
        #600 w = {15'h0, sdo};
        for (int i = 0; i < nbits; i++)
        begin
            if (cpol) sck = 1'b0;
            #HALF sck = 1'b1;
            w = {w[14:0], sdo};
            #HALF if (!cpol) sck = 1'b0;
        end
        #600 tail = sdo;
        cs_n = 1'b1;
        #HALF;
    endtask
    task automatic status(output logic s);
        sck = 1'b1;
        #17 cs_n = 1'b0;
        #600 s = sdo;
        cs_n = 1'b1;
        #HALF;
    endtask
endmodule

// ==== dv/tb_adc_cycle_serial_readout.sv ====
// Self-checking bench for the converter sequencer and serial read-out.
// Assumes the host model owns the link pins; core clock is 10 MHz.
module tb_adc_cycle_serial_readout;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 200;
    localparam int POR  = 20;
    // ====================
    // Hookup
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic signed [19:0] mod_code = '0;
    logic signed [19:0] off_code = '0;
    logic               sck;
    logic               cs_n;
    logic               sdo_o;
    logic               sdo_oe;
    logic               conv;
    logic               low_pw;
    logic               sdo_last = 1'b0;
    int                 mismatches = 0;
    int                 checked = 0;
    int                 mods [6] = '{0, 9000, 200000, -200000, -1, 16384};
    int                 offs [6] = '{0, -4000, 0, 0, 0, 20};
    // Released pin shows the inverse of its last value, never a held copy
    wire                sdo_w = sdo_oe ? sdo_o : ~sdo_last;
    always @(sdo_o or sdo_oe) if (sdo_oe) sdo_last = sdo_o;
    acr_top #(.RAW_W(20), .CONV_CYCLES(CONV), .POR_CYCLES(POR)) uut (
        .CLK(clk), .RESET(rst), .SCK(sck), .CS_N(cs_n), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
        .MOD_CODE(mod_code), .OFFSET_CODE(off_code), .CAL_STROBE(),
        .CONV_ACTIVE(conv), .LOW_POWER(low_pw));
    acr_host_model host (.sck(sck), .cs_n(cs_n), .sdo(sdo_w));
    initial forever #50 clk = ~clk;
    // ====================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_conv(input logic lvl, input int lim);
        int n;
        n = 0;
        while (conv !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check(16'(conv), 16'(lvl));
    endtask
    function automatic logic [15:0] expect_code(input int m, input int o);
        int d;
        d = m - o;
        if (d > 32767) d = 32767;
        if (d < -32768) d = -32768;
        return 16'(d + 32768);
    endfunction
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====================
    // Scenarios
    task automatic t_power_up();
        logic s;
        check(16'(conv), 16'h0);
        wait_conv(1'b1, POR + 4);
        host.status(s);
        check(16'(s), 16'h1);
        check(16'(conv), 16'h1);
        wait_conv(1'b0, CONV + 4);
        host.status(s);
        check(16'(s), 16'h0);
        repeat (4) @(negedge clk);
        check(16'(low_pw), 16'h1);
        $display("test power_up done");
    endtask
    task automatic t_abort();
        logic [15:0] w;
        logic [15:0] e;
        logic        tail;
        host.frame(1'b0, 0, w, tail);
        check(16'(w[0]), 16'h1);
        @(negedge clk);
        mod_code = -20'sd3;
        wait_conv(1'b1, 8);
        wait_conv(1'b0, CONV + 4);
        e = expect_code(-3, 0);
        host.frame(1'b0, 5, w, tail);
        check(16'(w[4:0]), 16'(e[15:11]));
        $display("test abort done");
    endtask
    task automatic t_read(input logic cpol, input int m, input int o);
        logic [15:0] w;
        logic        tail;
        @(negedge clk);
        mod_code = 20'(m);
        off_code = 20'(o);
        wait_conv(1'b1, 8);
        wait_conv(1'b0, CONV + 4);
        mod_code = ~mod_code;
        host.frame(cpol, 16, w, tail);
        check(w, expect_code(m, o));
        if (!cpol) check(16'(tail), 16'h1);
        $display("test read %h done", w);
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_power_up();
        t_abort();
        for (int i = 0; i < 6; i++) t_read(i[0], mods[i], offs[i]);
        close_out();
    end
    initial
    begin
        #1_000_000;
        mismatches++;
        close_out();
    end
endmodule
